/* rtl/cond_eval.sv */
`timescale 1ns/10ps
`default_nettype none
`include "window_skip_defines.svh"
module cond_eval
    import window_skip_pkg::*;
(
    input wire logic [3:0] condition_selector,
    input wire flags_t flags,
    output logic cond_true
);
    logic nxv;
    assign nxv = flags.n ^ flags.v;
    // -----------------------------------------
    // Condition table
    // -----------------------------------------
    always_comb begin
        unique case (condition_selector)
            4'h0: cond_true = flags.c;
            4'h1: cond_true = !flags.c;
            4'h2: cond_true = flags.z;
            4'h3: cond_true = !flags.z;
            4'h4: cond_true = flags.n;
            4'h5: cond_true = !flags.n;
            4'h6: cond_true = !nxv;
            4'h7: cond_true = nxv;
            4'h8: cond_true = flags.z | nxv;
            4'h9: cond_true = !(flags.z | nxv);
            4'ha: cond_true = flags.v;
            4'hb: cond_true = !flags.v;
            4'hc: cond_true = flags.c | flags.z;
            4'hd: cond_true = !(flags.c | flags.z);
            // Codes 0xe and 0xf have no condition; they never skip.
            default: cond_true = 1'b0;
        endcase
    end
endmodule : cond_eval
`default_nettype wire

/* rtl/window_skip_defines.svh */
`ifndef WINDOW_SKIP_DEFINES_SVH
`define WINDOW_SKIP_DEFINES_SVH
`define OPC_SAVE_TOP 16'h7800
`define OPC_SAVE_MASK 16'hff00
`define OPC_SIGN_EXTEND_HALFWORD_OP 16'h7c80
`define OPC_SIGN_EXTEND_BYTE_OP 16'h7c60
`define OPC_RW_MASK 16'hffe0
`define OPC_SKNZ 16'h7f40
`define OPC_SKZ 16'h7ec0
`define OPC_SKB0 16'h5000
`define OPC_SKB1 16'h5400
`define OPC_RI5_MASK 16'hfc00
`define OPC_SKCC 16'h7ee0
`define OPC_I4_MASK 16'hfff0
`define OPC_PFX 16'h9800
`define OPC_PFX_MASK 16'hf800
`define PC_STEP_NEXT 32'h0000_0002
`define PC_STEP_SKIP 32'h0000_0004
`define PC_STEP_SKIP_PFX 32'h0000_0006
`define WIN_STEP 5'h01
`define TRAP_UNDERFLOW 6'h01
`define FRAME_SCALE_SHIFT 2
`define RESET_PC 32'h0000_0000
`define RESET_WINDOW 5'h00
`endif

/* rtl/window_skip_exec.sv */
`timescale 1ns/10ps
`default_nettype none
`include "window_skip_defines.svh"
module window_skip_exec
    import window_skip_pkg::*;
#(
    parameter int WIN_W = 5
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire fetch_t fetch,
    input wire logic [31:0] operand_a_register,
    input wire logic [31:0] frame_pointer_reg,
    input wire logic [4:0] operand_a_index,
    input wire logic [4:0] stack_pointer_index,
    input wire logic [WIN_W-1:0] lower_window_limit,
    input wire flags_t flags_in,
    output logic [31:0] pc_reg,
    output logic [WIN_W-1:0] current_window_pointer,
    output logic [10:0] prefix_constant_reg,
    output reg_write_t rf_write_reg,
    output logic trap_req_reg,
    output logic [5:0] trap_num_reg,
    output flags_t flags_out_reg,
    output logic op_done_reg
);
    // -----------------------------------------
    // Decode
    // -----------------------------------------
    logic is_save, is_sx16, is_sx8, is_sknz, is_skz, is_skb0, is_skb1, is_skcc, is_pfx;
    logic next_is_pfx, cond_true, skip_take, bit_sel;
    logic [4:0] bit_index_immediate;
    logic [3:0] condition_selector;
    logic [7:0] frame_size_immediate;
    logic [10:0] prefix_immediate;
    logic [31:0] pc_next, sp_next;

    assign is_save = (fetch.word & `OPC_SAVE_MASK) == `OPC_SAVE_TOP;
    assign is_sx16 = (fetch.word & `OPC_RW_MASK) == `OPC_SIGN_EXTEND_HALFWORD_OP;
    assign is_sx8 = (fetch.word & `OPC_RW_MASK) == `OPC_SIGN_EXTEND_BYTE_OP;
    assign is_sknz = (fetch.word & `OPC_RW_MASK) == `OPC_SKNZ;
    assign is_skz = (fetch.word & `OPC_RW_MASK) == `OPC_SKZ;
    assign is_skb0 = (fetch.word & `OPC_RI5_MASK) == `OPC_SKB0;
    assign is_skb1 = (fetch.word & `OPC_RI5_MASK) == `OPC_SKB1;
    assign is_skcc = (fetch.word & `OPC_I4_MASK) == `OPC_SKCC;
    assign is_pfx = (fetch.word & `OPC_PFX_MASK) == `OPC_PFX;
    assign next_is_pfx = (fetch.next_word & `OPC_PFX_MASK) == `OPC_PFX;
    assign bit_index_immediate = fetch.word[9:5];
    assign condition_selector = fetch.word[3:0];
    assign frame_size_immediate = fetch.word[7:0];
    assign prefix_immediate = fetch.word[10:0];
    assign bit_sel = operand_a_register[bit_index_immediate];

    cond_eval u_cond (
        .condition_selector(condition_selector),
        .flags(flags_in),
        .cond_true(cond_true)
    );

    // -----------------------------------------
    // Skip decision and program counter
    // -----------------------------------------
    always_comb begin
        skip_take = (is_skb0 && !bit_sel)
            || (is_skb1 && bit_sel)
            || (is_sknz && (operand_a_register != 32'h0000_0000))
            || (is_skz && (operand_a_register == 32'h0000_0000))
            || (is_skcc && cond_true);
        if (!skip_take) begin
            pc_next = pc_reg + `PC_STEP_NEXT;
        end else if (next_is_pfx) begin
            pc_next = pc_reg + `PC_STEP_SKIP_PFX;
        end else begin
            pc_next = pc_reg + `PC_STEP_SKIP;
        end
    end

    // Stack pointer of the new window; the cast keeps the result in 32 bits and the shift scales the frame size by 4.
    assign sp_next = frame_pointer_reg
        - (32'({24'h00_0000, frame_size_immediate}) << `FRAME_SCALE_SHIFT);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pc_reg <= `RESET_PC;
        end else if (clk_en && fetch.valid) begin
            pc_reg <= pc_next;
        end
    end

    // -----------------------------------------
    // Register window
    // -----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            current_window_pointer <= WIN_W'(`RESET_WINDOW);
        end else if (clk_en && fetch.valid && is_save) begin
            // The window still moves on underflow; the trap handler spills it.
            current_window_pointer <= current_window_pointer - WIN_W'(`WIN_STEP);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trap_req_reg <= 1'b0;
            trap_num_reg <= 6'h00;
        end else if (clk_en) begin
            trap_req_reg <= fetch.valid && is_save
                && (current_window_pointer == lower_window_limit);
            trap_num_reg <= `TRAP_UNDERFLOW;
        end
    end

    // -----------------------------------------
    // Register file write-back
    // -----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rf_write_reg <= '0;
        end else if (clk_en) begin
            rf_write_reg.wr_en <= fetch.valid && (is_save || is_sx16 || is_sx8);
            if (is_save) begin
                rf_write_reg.index <= stack_pointer_index;
                rf_write_reg.data <= sp_next;
            end else if (is_sx16) begin
                rf_write_reg.index <= operand_a_index;
                rf_write_reg.data <= {{16{operand_a_register[15]}}, operand_a_register[15:0]};
            end else begin
                rf_write_reg.index <= operand_a_index;
                rf_write_reg.data <= {{24{operand_a_register[7]}}, operand_a_register[7:0]};
            end
        end
    end

    // -----------------------------------------
    // Prefix constant and flags
    // -----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prefix_constant_reg <= 11'h000;
        end else if (clk_en && fetch.valid) begin
            prefix_constant_reg <= is_pfx ? prefix_immediate : 11'h000;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flags_out_reg <= '0;
            op_done_reg <= 1'b0;
        end else if (clk_en) begin
            flags_out_reg <= flags_in;
            op_done_reg <= fetch.valid;
        end
    end

    // -----------------------------------------
    // Checks
    // -----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence save_issue_s;
        clk_en && fetch.valid && is_save;
    endsequence

    window_step_a: assert property (save_issue_s |=> current_window_pointer == $past(current_window_pointer) - WIN_W'(1)) else $error("window pointer not decremented");
    underflow_trap_a: assert property ((save_issue_s and (current_window_pointer == lower_window_limit)) |=> trap_req_reg && trap_num_reg == 6'h01) else $error("underflow trap missing");
    no_false_trap_a: assert property (clk_en && !(fetch.valid && is_save && current_window_pointer == lower_window_limit) |=> !trap_req_reg) else $error("spurious trap");
    stack_write_a: assert property (save_issue_s |=> rf_write_reg.wr_en && rf_write_reg.data == $past(frame_pointer_reg) - ($past(32'(frame_size_immediate)) * 4)) else $error("stack pointer wrong");
    half_extend_a: assert property (clk_en && fetch.valid && is_sx16 |=> rf_write_reg.data[31:16] == {16{rf_write_reg.data[15]}} && rf_write_reg.data[15:0] == $past(operand_a_register[15:0])) else $error("halfword extend wrong");
    byte_extend_a: assert property (clk_en && fetch.valid && is_sx8 |=> rf_write_reg.data[31:8] == {24{rf_write_reg.data[7]}} && rf_write_reg.data[7:0] == $past(operand_a_register[7:0])) else $error("byte extend wrong");
    bit_clear_skip_a: assert property (clk_en && fetch.valid && is_skb0 && !operand_a_register[fetch.word[9:5]] && !next_is_pfx |=> pc_reg == $past(pc_reg) + 32'h4) else $error("bit clear skip wrong");
    bit_set_skip_a: assert property (clk_en && fetch.valid && is_skb1 && operand_a_register[fetch.word[9:5]] && !next_is_pfx |=> pc_reg == $past(pc_reg) + 32'h4) else $error("bit set skip wrong");
    zero_skip_a: assert property (clk_en && fetch.valid && (is_skz || is_sknz) && !next_is_pfx && ((operand_a_register == 0) == is_skz) |=> pc_reg == $past(pc_reg) + 32'h4) else $error("zero test skip wrong");
    prefix_pair_a: assert property (clk_en && fetch.valid && skip_take && next_is_pfx |=> pc_reg == $past(pc_reg) + 32'h6) else $error("prefix pair not skipped");
    cond_skip_a: assert property (clk_en && fetch.valid && is_skcc && fetch.word[3:0] == 4'h2 && flags_in.z && !next_is_pfx |=> pc_reg == $past(pc_reg) + 32'h4) else $error("condition skip wrong");
    no_skip_step_a: assert property (clk_en && fetch.valid && !skip_take |=> pc_reg == $past(pc_reg) + 32'h2) else $error("sequential step wrong");
    flags_kept_a: assert property (clk_en |=> flags_out_reg == $past(flags_in)) else $error("flags changed");
    prefix_clear_a: assert property (clk_en && fetch.valid && !is_pfx |=> prefix_constant_reg == 11'h000) else $error("prefix constant not cleared");
endmodule : window_skip_exec
`default_nettype wire

/* rtl/window_skip_pkg.sv */
package window_skip_pkg;
    typedef struct packed {
        logic n;
        logic v;
        logic z;
        logic c;
    } flags_t;
    typedef struct packed {
        logic [15:0] word;
        logic [15:0] next_word;
        logic valid;
    } fetch_t;
    typedef struct packed {
        logic wr_en;
        logic [4:0] index;
        logic [31:0] data;
    } reg_write_t;
endpackage : window_skip_pkg

/* sim/window_save_sign_extend_skip_exec_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "window_skip_defines.svh"
module window_save_sign_extend_skip_exec_bench
    import window_skip_pkg::*;
;
logic clk_sys, arst_n, clk_en;
fetch_t fetch;
logic [31:0] operand_a_register, frame_pointer_reg, pc_reg, exp_pc, a;
logic [4:0] operand_a_index, stack_pointer_index, lower_window_limit, current_window_pointer;
logic [4:0] exp_cwp, lim, b, r;
logic [10:0] prefix_constant_reg, k;
reg_write_t rf_write_reg;
logic trap_req_reg, op_done_reg, t, prefix_instruction;
logic [5:0] trap_num_reg;
flags_t flags_in, flags_out_reg, f;
logic [7:0] imm;
logic [15:0] w, nw;
int num_errors, check_count, cycles, i;
// ----------------------------------------
// Device under test and clock.
// ----------------------------------------
window_skip_exec #(.WIN_W(5)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
    .fetch(fetch), .operand_a_register(operand_a_register),
    .frame_pointer_reg(frame_pointer_reg), .operand_a_index(operand_a_index),
    .stack_pointer_index(stack_pointer_index), .lower_window_limit(lower_window_limit),
    .flags_in(flags_in), .pc_reg(pc_reg), .current_window_pointer(current_window_pointer),
    .prefix_constant_reg(prefix_constant_reg), .rf_write_reg(rf_write_reg),
    .trap_req_reg(trap_req_reg), .trap_num_reg(trap_num_reg),
    .flags_out_reg(flags_out_reg), .op_done_reg(op_done_reg));
initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
end
// The whole run is some 120 cycles, so a ceiling of 2000 only trips on a real hang.
always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 2000) begin
        num_errors++;
        results();
    end
end
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
        num_errors++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
endtask : chk
task automatic results;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask : results
function automatic logic cond(input logic [3:0] s, input flags_t x);
    logic nv;
    logic [15:0] tt;
    nv = x.n ^ x.v;
    tt = {2'b00, !(x.c | x.z), x.c | x.z, !x.v, x.v, !(x.z | nv), x.z | nv, nv, !nv,
        !x.n, x.n, !x.z, x.z, !x.c, x.c};
    return tt[s];
endfunction : cond
// Drives one instruction on the falling edge and checks the common results.
task automatic exec(input logic [15:0] iw, input logic [31:0] dpc, input logic [10:0] ek);
    @(negedge clk_sys);
    fetch = '{word: iw, next_word: nw, valid: 1'b1};
    operand_a_register = a;
    flags_in = f;
    operand_a_index = 5'($urandom);
    stack_pointer_index = 5'($urandom);
    frame_pointer_reg = $urandom;
    lower_window_limit = lim;
    @(posedge clk_sys);
    #1;
    exp_pc = exp_pc + dpc;
    chk(pc_reg, exp_pc);
    chk(32'(prefix_constant_reg), 32'(ek));
    chk(32'(flags_out_reg), 32'(f));
    chk(32'(op_done_reg), 32'h1);
endtask : exec
initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    fetch = '0;
    {operand_a_register, frame_pointer_reg, operand_a_index, stack_pointer_index} = '0;
    {lower_window_limit, flags_in, lim, a, f, exp_pc, exp_cwp} = '0;
    nw = 16'h0000;
    void'($urandom(32'hcd81));
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    #1;
    chk(pc_reg, 32'h0000_0000);
    for (i = 0; i < 8; i++) begin
        lim = i[0] ? exp_cwp : exp_cwp + 5'h03;
        imm = (i < 2) ? {8{i[0]}} : 8'($urandom);
        f = 4'($urandom);
        exec(`OPC_SAVE_TOP | {8'h00, imm}, 32'h2, 11'h000);
        exp_cwp = exp_cwp - 5'h01;
        chk(32'(current_window_pointer), 32'(exp_cwp));
        chk(rf_write_reg.data, frame_pointer_reg - {22'h0, imm, 2'b00});
        chk({rf_write_reg.wr_en, rf_write_reg.index}, {1'b1, stack_pointer_index});
        chk(32'(trap_req_reg), 32'(i[0]));
        if (i[0]) chk(32'(trap_num_reg), 32'h1);
    end
    $display("window save test done");
    for (i = 0; i < 8; i++) begin
        a = (i == 0) ? 32'h0000_8080 : (i == 1) ? 32'hffff_7f7f : $urandom;
        k = 11'($urandom);
        exec(`OPC_PFX | {5'h00, k}, 32'h2, k);
        exec(`OPC_SIGN_EXTEND_HALFWORD_OP | 16'($urandom % 32), 32'h2, 11'h000);
        chk(rf_write_reg.data, {{16{a[15]}}, a[15:0]});
        chk({rf_write_reg.wr_en, rf_write_reg.index}, {1'b1, operand_a_index});
        exec(`OPC_SIGN_EXTEND_BYTE_OP | 16'($urandom % 32), 32'h2, 11'h000);
        chk(rf_write_reg.data, {{24{a[7]}}, a[7:0]});
        chk({rf_write_reg.wr_en, rf_write_reg.index}, {1'b1, operand_a_index});
    end
    $display("sign extend test done");
    for (i = 0; i < 80; i++) begin
        b = (i < 10) ? {5{i[1]}} : 5'($urandom);
        r = 5'($urandom);
        a = (i % 3 == 0) ? 32'h0 : (i % 3 == 1) ? (32'h1 << b) : $urandom;
        f = 4'($urandom);
        prefix_instruction = 1'($urandom);
        nw = prefix_instruction ? (`OPC_PFX | 16'($urandom % 2048)) : 16'h3000;
        case (i % 5)
            0: begin w = `OPC_SKB0 | {6'h00, b, r}; t = !a[b]; end
            1: begin w = `OPC_SKB1 | {6'h00, b, r}; t = a[b]; end
            2: begin w = `OPC_SKNZ | {11'h000, r}; t = (a != 32'h0); end
            3: begin w = `OPC_SKZ | {11'h000, r}; t = (a == 32'h0); end
            default: begin w = `OPC_SKCC | 16'((i / 5) % 16); t = cond(4'((i / 5) % 16), f); end
        endcase
        exec(w, t ? (prefix_instruction ? 32'h6 : 32'h4) : 32'h2, 11'h000);
        chk(32'(rf_write_reg.wr_en), 32'h0);
    end
    $display("skip test done");
    @(negedge clk_sys);
    clk_en = 1'b0;
    @(posedge clk_sys);
    #1;
    chk(pc_reg, exp_pc);
    // A low enable freezes every register, so the last done pulse holds too.
    chk(32'(op_done_reg), 32'h1);
    chk(32'(current_window_pointer), 32'(exp_cwp));
    @(negedge clk_sys);
    fetch.valid = 1'b0;
    clk_en = 1'b1;
    $display("freeze test done");
    results();
end
endmodule : window_save_sign_extend_skip_exec_bench
`default_nettype wire
